// >>> verilog/phy_link_result_pkg.sv
// package for the phy link result status register block
// shared by the design and the bench; no module here
package phy_link_result_pkg;
	// register index and byte address on the bus
	localparam logic [4:0]  STATUS_INDEX = 5'h1f;             // index 31
	localparam logic [7:0]  STATUS_ADDR  = 8'h7c;             // index times four
	localparam int          ADDR_W       = 8;                 // bus address bits decoded
	localparam int          REG_W        = 16;                // register width
	// field positions
	localparam int          AUTODONE_BIT = 12;                // negotiation finished
	localparam int          RSV_HI_MSB   = 11;                // writable reserved field
	localparam int          RSV_HI_LSB   = 5;
	localparam int          MODE_MSB     = 4;                 // speed and duplex code
	localparam int          MODE_LSB     = 2;
	localparam int          RSV_LO_MSB   = 1;                 // low reserved bits
	// reset values
	localparam logic [6:0]  RSV_HI_RESET = 7'h02;             // pattern 0000010b
	localparam logic [1:0]  RSV_LO_RESET = 2'h0;
	localparam logic [2:0]  MODE_RESET   = 3'h0;
	// mode codes
	localparam logic [2:0]  MODE_10_HALF  = 3'h1;
	localparam logic [2:0]  MODE_100_HALF = 3'h2;
	localparam logic [2:0]  MODE_10_FULL  = 3'h5;
	localparam logic [2:0]  MODE_100_FULL = 3'h6;
	// bus responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : phy_link_result_pkg

// >>> verilog/phy_link_result_status_reg.sv
// phy link result status register behind an axi4-lite slave
// assumes one clock, synchronous inputs, phy status from the transceiver core
//
// Summary of operation
// RULE_01: sixteen-bit register at index thirty-one
// RULE_02: bit twelve shows negotiation finished, resets zero
// RULE_03: bits eleven to five reset 0000010b, writable
// RULE_04: bits four to two report speed and duplex
// RULE_05: top bits read zero; low two bits store
`timescale 1ns/1ps
module phy_link_result_status_reg
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// status from the transceiver
	input  wire logic        anegDone,      // negotiation finished level
	input  wire logic [2:0]  linkMode,      // resolved speed and duplex
	// axi4-lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import phy_link_result_pkg::*;

	// byte lane split of the writable reserved field
	localparam int LANE_W   = 8;                          // bits per strobe lane
	localparam int HI_SPLIT = LANE_W - RSV_HI_LSB;        // field bits in lane 0
	localparam int HI_TOP   = RSV_HI_MSB - RSV_HI_LSB;    // field top within its store

	// refuse a field map that does not fill the register or the lanes
	if (REG_W != 16 || AUTODONE_BIT != RSV_HI_MSB + 1 || RSV_HI_LSB != MODE_MSB + 1 ||
		MODE_LSB != RSV_LO_MSB + 1 || HI_SPLIT < 1 || HI_TOP < HI_SPLIT ||
		ADDR_W < 8 || ADDR_W > 31) begin : g_bad_map
		$error("register field map does not fit");
	end

	// stored fields
	logic             doneReg;       // latched negotiation state
	logic [2:0]       modeReg;       // latched mode code
	logic [6:0]       rsvHiReg;      // writable reserved pattern
	logic [1:0]       rsvLoReg;      // writable reserved low bits
	// write channel capture
	logic             awHeld;        // write address taken
	logic             wHeld;         // write data taken
	logic [ADDR_W-1:0] awAddrReg;    // captured write address
	logic [31:0]      wDataReg;      // captured write data
	logic [3:0]       wStrbReg;      // captured strobes

	// mode codes the field may show; others are reserved
	function automatic logic modeValid(input logic [2:0] m);
		modeValid = (m == MODE_10_HALF) || (m == MODE_100_HALF) ||
			(m == MODE_10_FULL) || (m == MODE_100_FULL);
	endfunction : modeValid

	// decoding
	wire logic        doWrite = awHeld && wHeld && !s_axi_bvalid;
	wire logic        wrHit   = (awAddrReg == STATUS_ADDR);                          // RULE_01
	wire logic        rdHit   = (s_axi_araddr[ADDR_W-1:0] == STATUS_ADDR) &&
		(s_axi_araddr[31:ADDR_W] == '0);                                            // RULE_01
	wire logic        doRead  = s_axi_arvalid && s_axi_arready;
	wire logic [15:0] regView = {3'h0, doneReg, rsvHiReg, modeReg, rsvLoReg};        // RULE_05
	wire logic [2:0]  modeNext = modeValid(linkMode) ? linkMode : MODE_RESET;       // RULE_04

	// status capture from the transceiver
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			doneReg <= 1'b0;                                                          // RULE_02
			modeReg <= MODE_RESET;                                                    // RULE_04
		end else begin
			doneReg <= anegDone;                                                      // RULE_02
			modeReg <= modeNext;                                                      // RULE_04
		end
	end

	// writable reserved fields, byte lanes respected
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rsvHiReg <= RSV_HI_RESET;                                                 // RULE_03
			rsvLoReg <= RSV_LO_RESET;                                                 // RULE_05
		end else if (doWrite && wrHit) begin
			if (wStrbReg[0]) begin
				rsvLoReg <= wDataReg[RSV_LO_MSB:0];                                   // RULE_05
				rsvHiReg[HI_SPLIT-1:0] <= wDataReg[LANE_W-1:RSV_HI_LSB];              // RULE_03
			end
			if (wStrbReg[1]) begin
				rsvHiReg[HI_TOP:HI_SPLIT] <= wDataReg[RSV_HI_MSB:LANE_W];             // RULE_03
			end
		end
	end

	// write address and data taken independently
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awHeld    <= 1'b0;
			wHeld     <= 1'b0;
			awAddrReg <= '0;
			wDataReg  <= '0;
			wStrbReg  <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld    <= 1'b1;
				awAddrReg <= (s_axi_awaddr[31:ADDR_W] == '0) ? s_axi_awaddr[ADDR_W-1:0] : '1;
			end else if (doWrite) begin
				awHeld <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld    <= 1'b1;
				wDataReg <= s_axi_wdata;
				wStrbReg <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld <= 1'b0;
			end
		end
	end

	// ready flags and write response
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: one read in flight
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !doRead;
			if (doRead) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdHit ? {16'h0000, regView} : 32'h0000_0000;           // RULE_01
				s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// checks
	// done bit is the negotiation level one cycle late, both ways
	property p_done_follows;                                                     // RULE_02
		@(posedge clk) disable iff (!rst_n) rst_n |=> doneReg == $past(anegDone);
	endproperty
	a_done_follows: assert property (p_done_follows) else $error("done bit lags"); // RULE_02
	property p_mode_legal;
		@(posedge clk) disable iff (!rst_n) modeReg == MODE_RESET || modeValid(modeReg);
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("reserved mode code"); // RULE_04
	property p_top_zero;
		@(posedge clk) disable iff (!rst_n) s_axi_rvalid |-> s_axi_rdata[15:13] == 3'h0;
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("top bits nonzero"); // RULE_05
	property p_reset_pattern;
		@(posedge clk) !rst_n |=> rsvHiReg == RSV_HI_RESET && rsvLoReg == RSV_LO_RESET;
	endproperty
	a_reset_pattern: assert property (p_reset_pattern) else $error("bad reset"); // RULE_03
	property p_read_answer;
		@(posedge clk) disable iff (!rst_n) doRead |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("no read answer"); // RULE_01

	// mode field shows the transceiver code, reserved codes as zero
	property p_mode_follows;                                                     // RULE_04
		@(posedge clk) disable iff (!rst_n)
			rst_n |=> modeReg == (modeValid($past(linkMode)) ? $past(linkMode) : MODE_RESET);
	endproperty
	a_mode_follows: assert property (p_mode_follows) else $error("mode field lags"); // RULE_04

	// reserved store moves only on a write that hits the register
	property p_rsv_hold;                                                         // RULE_05
		@(posedge clk) disable iff (!rst_n)
			!(doWrite && wrHit) |=> $stable(rsvHiReg) && $stable(rsvLoReg);
	endproperty
	a_rsv_hold: assert property (p_rsv_hold) else $error("reserved bits moved"); // RULE_05

	// both write halves held: the response follows at the next edge
	sequence s_write_pair;
		awHeld && wHeld && !s_axi_bvalid;
	endsequence
	property p_write_answer;                                                     // RULE_01
		@(posedge clk) disable iff (!rst_n) s_write_pair |=> s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("no write answer"); // RULE_01

	// a write to any other place is refused with an error response
	property p_write_refused;                                                    // RULE_01
		@(posedge clk) disable iff (!rst_n)
			s_write_pair ##0 !wrHit |=> s_axi_bresp == RESP_SLVERR;
	endproperty
	a_write_refused: assert property (p_write_refused) else $error("bad write taken"); // RULE_01

	// address channel refuses a second write while one is pending
	property p_aw_quiet;                                                         // RULE_01
		@(posedge clk) disable iff (!rst_n) (awHeld || s_axi_bvalid) |-> !s_axi_awready;
	endproperty
	a_aw_quiet: assert property (p_aw_quiet) else $error("write address taken while busy"); // RULE_01
endmodule : phy_link_result_status_reg

// >>> sim/phy_link_result_status_reg_test.sv
// bench for the phy link result status register block
// drives the axi4-lite slave and the transceiver status inputs directly
`timescale 1ns/1ps
module phy_link_result_status_reg_test;
	import phy_link_result_pkg::*;
	logic        clk, rst_n, anegDone, awValid, wValid, bReady, arValid, rReady;
	logic        awReady, wReady, bValid, arReady, rValid;
	logic [2:0]  linkMode;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp, resp;
	logic [31:0] awAddr, wData, arAddr, rData, data;
	int          mismatches, checked;
	// block under test
	phy_link_result_status_reg dut (.clk(clk), .rst_n(rst_n), .anegDone(anegDone),
		.linkMode(linkMode), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
	// compare one value, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// compare one response code, four-state exact
	task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chkResp
	// one write, each channel dropped when taken; only the watchdog ends a wait
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		awAddr  <= a;
		wData   <= d;
		wStrb   <= s;
		awValid <= 1'b1;
		wValid  <= 1'b1;
		bReady  <= 1'b1;
		do begin
			@(posedge clk);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
		end while (bValid !== 1'b1);
		resp = bResp;
		bReady <= 1'b0;
	endtask : wr
	// one read, data taken with rvalid; only the watchdog ends a wait
	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		arAddr  <= a;
		arValid <= 1'b1;
		rReady  <= 1'b1;
		do begin
			@(posedge clk);
			if (arReady) arValid <= 1'b0;
		end while (rValid !== 1'b1);
		data = rData;
		resp = rResp;
		rReady <= 1'b0;
	endtask : rd
	// every mode code, reserved ones read as zero
	task automatic test_modes;
		logic [2:0] m;
		for (int c = 0; c < 8; c++) begin
			linkMode <= c[2:0];
			anegDone <= c[0];
			m = (c == 1 || c == 2 || c == 5 || c == 6) ? c[2:0] : 3'h0;
			rd(32'h7c);
			chk(data, {19'h0, c[0], RSV_HI_RESET, m, 2'h0});
		end
	endtask : test_modes
	// writable and fixed fields, byte lanes; bits 11:5 always written as 0000010b
	task automatic test_write;
		linkMode <= MODE_100_FULL;
		anegDone <= 1'b1;
		wr(32'h7c, 32'hffff_f05f, 4'hf);
		chkResp(resp, RESP_OKAY);
		rd(32'h7c);
		chk(data, 32'h105b);
		wr(32'h7c, 32'h0000_0040, 4'h2);
		rd(32'h7c);
		chk(data, 32'h105b);
		wr(32'h7c, 32'h0000_0040, 4'h1);
		rd(32'h7c);
		chk(data, 32'h1058);
	endtask : test_write
	// unmapped place refused, register untouched
	task automatic test_unmapped;
		wr(32'h78, 32'hffff, 4'hf);
		chkResp(resp, RESP_SLVERR);
		rd(32'h78);
		chkResp(resp, RESP_SLVERR);
		chk(data, 32'h0);
		rd(32'h7c);
		chk(data, 32'h1058);
	endtask : test_unmapped
	// print counts and verdict, end the run
	task automatic test_done;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	// clock, 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// watchdog against a hang
	initial begin
		#50000;
		mismatches++;
		test_done();
	end
	// main sequence
	initial begin
		{rst_n, anegDone, awValid, wValid, bReady, arValid, rReady} <= '0;
		{linkMode, wStrb, awAddr, wData, arAddr} <= '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(32'h7c);
		chk(data, 32'h40);
		test_modes();
		test_write();
		test_unmapped();
		test_done();
	end
endmodule : phy_link_result_status_reg_test
